//--- rtl/mdhl_pkg.sv
// Shared constants and types of the meter link: commands, dump layout, coefficient store.
// Assumes byte-wide SPI commands and a measurement engine on the system clock.

package mdhl_pkg;

	// ------------------------------------------------------------
	// Command and marker bytes
	// ------------------------------------------------------------
	localparam logic [7:0] CMD_CAL = 8'hEF;
	localparam logic [7:0] CMD_DUMP = 8'h45;
	localparam logic [7:0] CMD_LOAD = 8'h4C;
	localparam logic [7:0] CAL_DONE_MARK = 8'hFE;
	localparam logic [7:0] CAL_STATUS_DONE = 8'hEF;
	localparam logic [7:0] CAL_STATUS_CLR = 8'h00;
	localparam logic [7:0] TX_IDLE = 8'h00;

	// ------------------------------------------------------------
	// Calibration and pulse figures
	// ------------------------------------------------------------
	localparam logic [5:0] CAL_CYCLES = 6'h20;
	localparam logic [4:0] CAL_LAST = 5'(CAL_CYCLES - 6'h01);
	localparam logic [15:0] GAIN_UNITY = 16'h4000;
	localparam logic [15:0] COEF_ZERO = 16'h0000;
	localparam logic [14:0] PULSE_MIN = 15'h03E8;
	localparam logic [14:0] PULSE_MAX = 15'h4E20;
	localparam logic [14:0] QUANTA_PER_KWH = 15'h2710;

	// ------------------------------------------------------------
	// Coefficient store: gains, dc offsets, phase compensation
	// ------------------------------------------------------------
	localparam int GAIN_N = 9;
	localparam int OFS_N = 9;
	localparam int COEF_N = 36;
	localparam logic [5:0] OFS_BASE = 6'h09;
	localparam logic [5:0] PCOMP_BASE = 6'h12;
	localparam logic [5:0] COEF_LAST = 6'h23;

	// ------------------------------------------------------------
	// Dump byte positions
	// ------------------------------------------------------------
	localparam logic [8:0] OFF_FREQ = 9'h000;
	localparam logic [8:0] OFF_PWR = 9'h002;
	localparam logic [8:0] OFF_PF = 9'h00E;
	localparam logic [8:0] OFF_ENE = 9'h014;
	localparam logic [8:0] OFF_UNITS = 9'h020;
	localparam logic [8:0] OFF_COEF = 9'h023;
	localparam logic [8:0] OFF_STAT = 9'h047;
	localparam logic [8:0] OFF_PCOMP = 9'h048;
	localparam logic [8:0] OFF_GAP = 9'h06C;
	localparam logic [8:0] OFF_HARM = 9'h0D9;
	localparam logic [8:0] OFF_HARM_IA = 9'h11B;
	localparam logic [8:0] DUMP_LAST = 9'h1E0;

	typedef enum logic [1:0] {
		MDHL_IDLE = 2'b00,
		MDHL_DUMP = 2'b01,
		MDHL_LOAD = 2'b10
	} mdhl_state_e;

	typedef struct packed {
		logic [15:0] freq;
		logic [2:0][31:0] pwr;
		logic [2:0][15:0] pf;
		logic [2:0][31:0] ene;
		logic [2:0] units;
	} mdhl_meas_s;

	typedef logic [131:0][15:0] mdhl_harm_t;
	typedef logic [8:0][15:0] mdhl_ofs_t;
	typedef logic [35:0][15:0] mdhl_coef_t;

endpackage

//--- rtl/mdhl_spi_link.sv
// SPI mode 0 byte link: shifter on sclk, byte events handed to clk by a toggle.
// Assumes cs_n framing and a pause between bytes so tx_byte settles.

`timescale 1ns/1ns
`default_nettype none

module mdhl_spi_link (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic mosi,
	output logic miso,
	output logic miso_oe,
	input wire logic [7:0] tx_byte,
	output logic [7:0] rx_byte,
	output logic rx_evt,
	output logic frame_end
);

	logic [2:0] bit_q;
	logic [6:0] sh_q;
	logic [7:0] hold_q;
	logic tgl_q;
	logic [7:0] txs_q;
	logic [2:0] tsync_q;
	logic [2:0] csync_q;

	// ------------------------------------------------------------
	// Link domain
	// ------------------------------------------------------------
	always_ff @(posedge sclk or posedge cs_n) begin
		if (cs_n) begin
			bit_q <= 3'h0;
			sh_q <= 7'h00;
		end else begin
			bit_q <= bit_q + 3'h1;
			sh_q <= {sh_q[5:0], mosi};
		end
	end

	// Byte and toggle survive the frame end so the last byte is not lost
	always_ff @(posedge sclk or negedge rst_n) begin
		if (!rst_n) begin
			hold_q <= 8'h00;
			tgl_q <= 1'b0;
		end else if (!cs_n && bit_q == 3'h7) begin
			hold_q <= {sh_q, mosi};
			tgl_q <= ~tgl_q;
		end
	end

	always_ff @(negedge sclk or posedge cs_n) begin
		if (cs_n) begin
			txs_q <= 8'h00;
		end else if (bit_q == 3'h1) begin
			txs_q <= {tx_byte[6:0], 1'b0};
		end else begin
			txs_q <= {txs_q[6:0], 1'b0};
		end
	end

	assign miso = cs_n ? 1'b0 : ((bit_q == 3'h0) ? tx_byte[7] : txs_q[7]);
	assign miso_oe = ~cs_n;

	// ------------------------------------------------------------
	// System domain
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tsync_q <= 3'h0;
			csync_q <= 3'h7;
		end else begin
			tsync_q <= {tsync_q[1:0], tgl_q};
			csync_q <= {csync_q[1:0], cs_n};
		end
	end

	assign rx_evt = tsync_q[2] ^ tsync_q[1];
	assign frame_end = csync_q[1] & ~csync_q[2];
	assign rx_byte = hold_q;

endmodule

`default_nettype wire

//--- rtl/mdhl_epulse.sv
// Energy pulse generator: one output pulse per 1/k kWh of energy quanta.
// Assumes one quantum is 0.0001 kWh and quanta arrive at most every other cycle.

`timescale 1ns/1ns
`default_nettype none

module mdhl_epulse (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic quantum,
	input wire logic [14:0] k_const,
	output logic pulse
);

	logic [14:0] k_eff;
	logic [15:0] acc_q;
	logic [15:0] acc_d;
	logic due;
	logic pulse_q;

	// Constant held inside the legal range
	assign k_eff = (k_const < mdhl_pkg::PULSE_MIN) ? mdhl_pkg::PULSE_MIN :
		(k_const > mdhl_pkg::PULSE_MAX) ? mdhl_pkg::PULSE_MAX : k_const;
	assign due = acc_q >= {1'b0, mdhl_pkg::QUANTA_PER_KWH};
	assign acc_d = acc_q - (due ? {1'b0, mdhl_pkg::QUANTA_PER_KWH} : 16'h0000)
		+ (quantum ? {1'b0, k_eff} : 16'h0000);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			acc_q <= 16'h0000;
			pulse_q <= 1'b0;
		end else begin
			acc_q <= acc_d;
			pulse_q <= due;
		end
	end

	assign pulse = pulse_q;

	property p_pulse_due;
		@(posedge clk) disable iff (!rst_n)
		due |=> pulse && (acc_q == $past(acc_d));
	endproperty
	a_pulse_due: assert property (p_pulse_due) else $error("pulse missing after full kWh share");

	property p_k_range;
		@(posedge clk) disable iff (!rst_n)
		quantum && !due |=> (acc_q - $past(acc_q)) >= {1'b0, mdhl_pkg::PULSE_MIN}
			&& (acc_q - $past(acc_q)) <= {1'b0, mdhl_pkg::PULSE_MAX};
	endproperty
	a_k_range: assert property (p_k_range) else $error("pulse constant out of range");

endmodule

`default_nettype wire

//--- rtl/mdhl_core.sv
// Meter link device end: command interpreter, dump serialiser, coefficient store,
// dc offset calibration sequencer and two energy pulse outputs.
// Assumes an SPI host on the pins and a measurement engine on clk.

`timescale 1ns/1ns
`default_nettype none

module mdhl_core (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic mosi,
	output logic miso,
	output logic miso_oe,
	input wire mdhl_pkg::mdhl_meas_s meas,
	input wire mdhl_pkg::mdhl_harm_t harm,
	input wire logic cycle_tick,
	input wire mdhl_pkg::mdhl_ofs_t ofs_new,
	input wire logic e_act_inc,
	input wire logic e_app_inc,
	input wire logic e_rea_inc,
	input wire logic pulse1_apparent,
	input wire logic [14:0] pulse_const,
	output mdhl_pkg::mdhl_coef_t coef,
	output logic cal_busy,
	output logic [1:0] epulse
);

	// ------------------------------------------------------------
	// Byte selection helpers
	// ------------------------------------------------------------
	// Sixteen-bit words go high byte first
	function automatic logic [7:0] byte16(input logic [15:0] v, input logic i);
		byte16 = i ? v[7:0] : v[15:8];
	endfunction

	// Low word first, each word high byte first
	function automatic logic [7:0] byte32(input logic [31:0] v, input logic [1:0] i);
		logic [15:0] w;
		w = i[1] ? v[31:16] : v[15:0];
		byte32 = byte16(w, i[0]);
	endfunction

	// Dump table: one byte per position
	function automatic logic [7:0] table_byte(
		input logic [8:0] p,
		input mdhl_pkg::mdhl_meas_s m,
		input mdhl_pkg::mdhl_coef_t c,
		input logic [7:0] st,
		input mdhl_pkg::mdhl_harm_t h
	);
		logic [8:0] r;
		logic [7:0] b;
		b = 8'h00;
		r = 9'h000;
		if (p < mdhl_pkg::OFF_PWR) begin
			b = byte16(m.freq, p[0]);
		end else if (p < mdhl_pkg::OFF_PF) begin
			r = p - mdhl_pkg::OFF_PWR;
			b = byte32(m.pwr[r[3:2]], r[1:0]);
		end else if (p < mdhl_pkg::OFF_ENE) begin
			r = p - mdhl_pkg::OFF_PF;
			b = byte16(m.pf[r[2:1]], r[0]);
		end else if (p < mdhl_pkg::OFF_UNITS) begin
			r = p - mdhl_pkg::OFF_ENE;
			b = byte32(m.ene[r[3:2]], r[1:0]);
		end else if (p < mdhl_pkg::OFF_COEF) begin
			r = p - mdhl_pkg::OFF_UNITS;
			b = {7'h00, m.units[r[1:0]]};
		end else if (p < mdhl_pkg::OFF_STAT) begin
			r = p - mdhl_pkg::OFF_COEF;
			b = byte16(c[r[5:1]], r[0]);
		end else if (p == mdhl_pkg::OFF_STAT) begin
			b = st;
		end else if (p < mdhl_pkg::OFF_GAP) begin
			r = p - mdhl_pkg::OFF_PCOMP;
			b = byte16(c[mdhl_pkg::PCOMP_BASE + {1'b0, r[5:1]}], r[0]);
		end else if (p >= mdhl_pkg::OFF_HARM && p <= mdhl_pkg::DUMP_LAST) begin
			r = p - mdhl_pkg::OFF_HARM;
			b = byte16(h[r[8:1]], r[0]);
		end
		table_byte = b;
	endfunction

	// ------------------------------------------------------------
	// SPI link
	// ------------------------------------------------------------
	logic [7:0] rx_byte;
	logic rx_evt;
	logic frame_end;
	logic [7:0] tx_q;
	logic [7:0] tx_d;

	mdhl_spi_link u_link (
		.clk(clk),
		.rst_n(rst_n),
		.sclk(sclk),
		.cs_n(cs_n),
		.mosi(mosi),
		.miso(miso),
		.miso_oe(miso_oe),
		.tx_byte(tx_q),
		.rx_byte(rx_byte),
		.rx_evt(rx_evt),
		.frame_end(frame_end)
	);

	// ------------------------------------------------------------
	// Command decode
	// ------------------------------------------------------------
	mdhl_pkg::mdhl_state_e st_q;
	mdhl_pkg::mdhl_state_e st_d;
	logic [8:0] ptr_q;
	logic [8:0] ptr_d;
	logic [5:0] lidx_q;
	logic [5:0] lidx_d;
	logic half_q;
	logic half_d;
	logic [7:0] hi_q;
	logic [7:0] hi_d;
	logic cal_q;
	logic cal_d;
	logic [4:0] ccnt_q;
	logic [4:0] ccnt_d;
	logic [7:0] stat_q;
	logic [7:0] stat_d;
	wire mdhl_pkg::mdhl_coef_t coef_q;
	logic idle_rx;
	logic is_cal;
	logic is_dump;
	logic is_load;
	logic cal_end;
	logic dump_last;
	logic word_wr;
	logic load_last;

	assign idle_rx = rx_evt && (st_q == mdhl_pkg::MDHL_IDLE);
	assign is_cal = idle_rx && (rx_byte == mdhl_pkg::CMD_CAL);
	assign is_dump = idle_rx && (rx_byte == mdhl_pkg::CMD_DUMP);
	assign is_load = idle_rx && (rx_byte == mdhl_pkg::CMD_LOAD);
	assign cal_end = cal_q && cycle_tick && (ccnt_q == mdhl_pkg::CAL_LAST);
	assign dump_last = (st_q == mdhl_pkg::MDHL_DUMP) && rx_evt && (ptr_q == mdhl_pkg::DUMP_LAST);
	assign word_wr = (st_q == mdhl_pkg::MDHL_LOAD) && rx_evt && half_q;
	assign load_last = word_wr && (lidx_q == mdhl_pkg::COEF_LAST);

	// ------------------------------------------------------------
	// Transfer state machine
	// ------------------------------------------------------------
	always_comb begin
		st_d = st_q;
		ptr_d = ptr_q;
		case (st_q)
			mdhl_pkg::MDHL_IDLE: begin
				if (is_dump) begin
					st_d = mdhl_pkg::MDHL_DUMP;
					ptr_d = 9'h000;
				end else if (is_load) begin
					st_d = mdhl_pkg::MDHL_LOAD;
				end
			end
			mdhl_pkg::MDHL_DUMP: begin
				if (frame_end || dump_last) begin
					st_d = mdhl_pkg::MDHL_IDLE;
				end else if (rx_evt) begin
					ptr_d = ptr_q + 9'h001;
				end
			end
			mdhl_pkg::MDHL_LOAD: begin
				if (frame_end || load_last) begin
					st_d = mdhl_pkg::MDHL_IDLE;
				end
			end
			default: begin
				st_d = mdhl_pkg::MDHL_IDLE;
			end
		endcase
	end

	// Upload bytes pair high then low into one coefficient word
	assign lidx_d = (st_q != mdhl_pkg::MDHL_LOAD) ? 6'h00 :
		(word_wr ? lidx_q + 6'h01 : lidx_q);
	assign half_d = (st_q != mdhl_pkg::MDHL_LOAD) ? 1'b0 : (rx_evt ? ~half_q : half_q);
	assign hi_d = ((st_q == mdhl_pkg::MDHL_LOAD) && rx_evt && !half_q) ? rx_byte : hi_q;

	// Offset calibration counts measurement cycles
	assign cal_d = is_cal ? 1'b1 : (cal_end ? 1'b0 : cal_q);
	assign ccnt_d = is_cal ? 5'h00 : ((cal_q && cycle_tick) ? ccnt_q + 5'h01 : ccnt_q);
	// Completion wins over a restart in the same cycle
	assign stat_d = cal_end ? mdhl_pkg::CAL_STATUS_DONE :
		(is_cal ? mdhl_pkg::CAL_STATUS_CLR : stat_q);

	// Next byte to shift out
	assign tx_d = (st_d == mdhl_pkg::MDHL_DUMP) ? table_byte(ptr_d, meas, coef_q, stat_q, harm) :
		(st_q == mdhl_pkg::MDHL_DUMP) ? mdhl_pkg::TX_IDLE :
		(cal_end ? mdhl_pkg::CAL_DONE_MARK : tx_q);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= mdhl_pkg::MDHL_IDLE;
			ptr_q <= 9'h000;
			tx_q <= mdhl_pkg::TX_IDLE;
		end else begin
			st_q <= st_d;
			ptr_q <= ptr_d;
			tx_q <= tx_d;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			lidx_q <= 6'h00;
			half_q <= 1'b0;
			hi_q <= 8'h00;
		end else begin
			lidx_q <= lidx_d;
			half_q <= half_d;
			hi_q <= hi_d;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cal_q <= 1'b0;
			ccnt_q <= 5'h00;
			stat_q <= mdhl_pkg::CAL_STATUS_CLR;
		end else begin
			cal_q <= cal_d;
			ccnt_q <= ccnt_d;
			stat_q <= stat_d;
		end
	end

	// ------------------------------------------------------------
	// Coefficient store
	// ------------------------------------------------------------
	for (genvar i = 0; i < mdhl_pkg::COEF_N; i++) begin : g_coef
		logic sel_wr;
		logic sel_cal;
		assign sel_wr = word_wr && (lidx_q == 6'(i));
		if (i >= mdhl_pkg::GAIN_N && i < mdhl_pkg::GAIN_N + mdhl_pkg::OFS_N) begin : g_ofs
			assign sel_cal = cal_end;
		end else begin : g_plain
			assign sel_cal = 1'b0;
		end
		logic [15:0] word_q;
		always_ff @(posedge clk or negedge rst_n) begin
			if (!rst_n) begin
				word_q <= (i < mdhl_pkg::GAIN_N) ? mdhl_pkg::GAIN_UNITY : mdhl_pkg::COEF_ZERO;
			end else if (sel_cal) begin
				word_q <= ofs_new[(i + mdhl_pkg::OFS_N - mdhl_pkg::GAIN_N) % mdhl_pkg::OFS_N];
			end else if (sel_wr) begin
				word_q <= {hi_q, rx_byte};
			end
		end
		assign coef_q[i] = word_q;
	end

	assign coef = coef_q;
	assign cal_busy = cal_q;

	// ------------------------------------------------------------
	// Energy pulses
	// ------------------------------------------------------------
	logic first_quantum;

	assign first_quantum = pulse1_apparent ? e_app_inc : e_act_inc;

	mdhl_epulse u_pulse_main (
		.clk(clk),
		.rst_n(rst_n),
		.quantum(first_quantum),
		.k_const(pulse_const),
		.pulse(epulse[0])
	);

	mdhl_epulse u_pulse_reactive (
		.clk(clk),
		.rst_n(rst_n),
		.quantum(e_rea_inc),
		.k_const(pulse_const),
		.pulse(epulse[1])
	);

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	logic steady;

	assign steady = (st_q == mdhl_pkg::MDHL_DUMP) && !rx_evt && !frame_end;

	property p_cal_start;
		@(posedge clk) disable iff (!rst_n)
		is_cal |=> cal_busy && (ccnt_q == 5'h00)
			&& (stat_q == ($past(cal_end) ? mdhl_pkg::CAL_STATUS_DONE : mdhl_pkg::CAL_STATUS_CLR));
	endproperty
	a_cal_start: assert property (p_cal_start) else $error("offset calibration did not start");

	property p_cal_count;
		@(posedge clk) disable iff (!rst_n)
		cal_q && cycle_tick && !is_cal && (ccnt_q != mdhl_pkg::CAL_LAST)
			|=> cal_q && (ccnt_q == $past(ccnt_q) + 5'h01);
	endproperty
	a_cal_count: assert property (p_cal_count) else $error("calibration ended before 32 cycles");

	property p_cal_done;
		@(posedge clk) disable iff (!rst_n)
		cal_end && !is_cal && (st_q == mdhl_pkg::MDHL_IDLE) && !is_dump
			|=> !cal_busy && (tx_q == mdhl_pkg::CAL_DONE_MARK)
			&& (stat_q == mdhl_pkg::CAL_STATUS_DONE) && (coef_q[9] == $past(ofs_new[0]));
	endproperty
	a_cal_done: assert property (p_cal_done) else $error("completion mark or offsets missing");

	property p_dump_first;
		@(posedge clk) disable iff (!rst_n)
		is_dump |=> (st_q == mdhl_pkg::MDHL_DUMP) && (ptr_q == 9'h000)
			&& (tx_q == $past(meas.freq[15:8]));
	endproperty
	a_dump_first: assert property (p_dump_first) else $error("dump did not open with frequency");

	property p_word_order;
		@(posedge clk) disable iff (!rst_n)
		steady && (ptr_q == mdhl_pkg::OFF_PWR + 9'h002) |=> tx_q == $past(meas.pwr[0][31:24]);
	endproperty
	a_word_order: assert property (p_word_order) else $error("power high word sent too early");

	property p_energy;
		@(posedge clk) disable iff (!rst_n)
		steady && (ptr_q == mdhl_pkg::OFF_ENE) |=> tx_q == $past(meas.ene[0][15:8]);
	endproperty
	a_energy: assert property (p_energy) else $error("energy low word not first");

	property p_harm_loc;
		@(posedge clk) disable iff (!rst_n)
		steady && (ptr_q == mdhl_pkg::OFF_HARM_IA) |=> tx_q == $past(harm[33][15:8]);
	endproperty
	a_harm_loc: assert property (p_harm_loc) else $error("phase angle of current A misplaced");

	property p_units;
		@(posedge clk) disable iff (!rst_n)
		steady && (ptr_q == mdhl_pkg::OFF_UNITS) |=> tx_q == {7'h00, $past(meas.units[0])};
	endproperty
	a_units: assert property (p_units) else $error("current scaling flag wrong");

	property p_dump_end;
		@(posedge clk) disable iff (!rst_n)
		dump_last |=> (st_q == mdhl_pkg::MDHL_IDLE) && (tx_q == mdhl_pkg::TX_IDLE);
	endproperty
	a_dump_end: assert property (p_dump_end) else $error("dump did not end after last byte");

	property p_load_word;
		@(posedge clk) disable iff (!rst_n)
		word_wr && !cal_end |=> coef_q[$past(lidx_q)] == {$past(hi_q), $past(rx_byte)};
	endproperty
	a_load_word: assert property (p_load_word) else $error("uploaded coefficient not stored");

endmodule

`default_nettype wire

//--- tb/mdhl_host_model.sv
// SPI host model: mode 0, byte transfers, 30 ns serial clock that runs only inside frames.
// Assumes the device end answers on miso while cs_n is low.

`timescale 1ns/1ns
`default_nettype none

module mdhl_host_model (
	output logic sclk,
	output logic cs_n,
	output logic mosi,
	input wire logic miso,
	output logic [7:0] got,
	output logic got_stb
);
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		mosi = 1'b0;
		got = 8'h00;
		got_stb = 1'b0;
	end

	// Opens or closes a frame; a released mosi never keeps its last level
	task automatic sel(input logic on);
		#103 cs_n = !on;
		if (!on) mosi = !mosi;
		#100;
	endtask

	// One byte, MSB first, sampled on the rising edge, long pause after it
	task automatic xfer(input logic [7:0] tx, input logic chk);
		logic [7:0] r;
		for (int i = 7; i >= 0; i--) begin
			mosi = tx[i];
			#15 sclk = 1'b1;
			r[i] = miso;
			#15 sclk = 1'b0;
		end
		mosi = !tx[0];
		if (chk) begin
			got = r;
			got_stb = 1'b1;
			#1 got_stb = 1'b0;
		end
		#300;
	endtask
endmodule

`default_nettype wire

//--- tb/tb.sv
// Bench for the meter link device end: upload, calibration, full dump and pulse outputs.
// Assumes the host model drives the SPI pins and the bench drives the engine side.

`timescale 1ns/1ns
`default_nettype none

module tb;
	logic clk, rst_n, cycle_tick, e_act_inc, e_app_inc, e_rea_inc, pulse1_apparent, cal_busy;
	logic sclk, cs_n, mosi, miso, miso_oe, got_stb;
	logic [7:0] got, st;
	logic [14:0] pulse_const;
	logic [1:0] epulse;
	logic [31:0] seed;
	logic [258:0] mv;
	logic [15:0] ec [36];
	logic [7:0] q [$];
	mdhl_pkg::mdhl_meas_s meas;
	mdhl_pkg::mdhl_harm_t harm;
	mdhl_pkg::mdhl_ofs_t ofs_new;
	mdhl_pkg::mdhl_coef_t coef;
	int mismatches = 0, total_checks = 0, cyc = 0, n0 = 0, n1 = 0, a0, a1;

	mdhl_core u_dut (.clk(clk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n), .mosi(mosi),
		.miso(miso), .miso_oe(miso_oe), .meas(meas), .harm(harm), .cycle_tick(cycle_tick),
		.ofs_new(ofs_new), .e_act_inc(e_act_inc), .e_app_inc(e_app_inc), .e_rea_inc(e_rea_inc),
		.pulse1_apparent(pulse1_apparent), .pulse_const(pulse_const), .coef(coef),
		.cal_busy(cal_busy), .epulse(epulse));
	mdhl_host_model u_host (.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso), .got(got),
		.got_stb(got_stb));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	// Byte expected at one dump position
	function automatic logic [7:0] exp_b(input int p);
		int b;
		logic [31:0] d;
		logic [15:0] w;
		b = p;
		d = 32'h00000000;
		w = 16'h0000;
		if (p < 2) w = meas.freq;
		else if (p < 14) begin
			b = p - 2;
			d = meas.pwr[b / 4];
			w = (b % 4 < 2) ? d[15:0] : d[31:16];
		end else if (p < 20) begin
			b = p - 14;
			w = meas.pf[b / 2];
		end else if (p < 32) begin
			b = p - 20;
			d = meas.ene[b / 4];
			w = (b % 4 < 2) ? d[15:0] : d[31:16];
		end else if (p < 35) return {7'h00, meas.units[p - 32]};
		else if (p < 71) begin
			b = p - 35;
			w = ec[b / 2];
		end else if (p == 71) return st;
		else if (p < 108) begin
			b = p - 72;
			w = ec[18 + b / 2];
		end else if (p < 217) return 8'h00;
		else begin
			b = p - 217;
			w = harm[b / 2];
		end
		return (b % 2 != 0) ? w[7:0] : w[15:8];
	endfunction

	task automatic cmp8(input logic [7:0] a, input logic [7:0] e);
		total_checks++;
		if (a !== e) begin
			mismatches++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, a, e);
		end
	endtask

	task automatic cmp16(input logic [15:0] a, input logic [15:0] e);
		total_checks++;
		if (a !== e) begin
			mismatches++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, a, e);
		end
	endtask

	task automatic final_report();
		if (mismatches == 0 && total_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	always @(posedge got_stb) begin
		cmp8(got, (q.size() > 0) ? q.pop_front() : 8'hXX);
	end

	always @(negedge clk) begin
		n0 += epulse[0];
		n1 += epulse[1];
		cyc++;
		if (cyc == 60000) begin
			mismatches++;
			final_report();
		end
	end

	initial begin
		rst_n = 1'b0;
		{cycle_tick, e_act_inc, e_app_inc, e_rea_inc, pulse1_apparent} = 5'h00;
		pulse_const = 15'h03E8;
		{ofs_new, meas, harm, mv} = '0;
		seed = 32'h00012820;
		st = 8'h00;
		repeat (4) @(posedge clk);
		@(negedge clk);
		rst_n = 1'b1;
		for (int i = 0; i < 36; i++) cmp16(coef[i], (i < 9) ? 16'h4000 : 16'h0000);
		for (int i = 0; i < 9; i++) begin
			seed = lfsr(seed);
			mv = {mv[226:0], seed};
		end
		meas = mv;
		for (int i = 0; i < 132; i++) begin
			seed = lfsr(seed);
			harm[i] = seed[15:0];
		end
		u_host.sel(1'b1);
		u_host.xfer(8'h4C, 1'b0);
		for (int i = 0; i < 36; i++) begin
			seed = lfsr(seed);
			ec[i] = seed[15:0];
			u_host.xfer(ec[i][15:8], 1'b0);
			u_host.xfer(ec[i][7:0], 1'b0);
		end
		u_host.sel(1'b0);
		@(negedge clk);
		for (int i = 0; i < 36; i++) cmp16(coef[i], ec[i]);
		ofs_new = mv[258:115];
		u_host.sel(1'b1);
		cmp16({15'h0000, miso_oe}, 16'h0001);
		u_host.xfer(8'hEF, 1'b0);
		u_host.sel(1'b0);
		@(negedge clk);
		cmp16({15'h0000, cal_busy}, 16'h0001);
		cmp16({15'h0000, miso_oe}, 16'h0000);
		for (int t = 0; t < 32; t++) begin
			@(negedge clk);
			cycle_tick = 1'b1;
			@(negedge clk);
			cycle_tick = 1'b0;
			if (t == 30) cmp16({15'h0000, cal_busy}, 16'h0001);
		end
		// Short pause stands in for the host's one-second wait before the dump
		repeat (4) @(negedge clk);
		cmp16({15'h0000, cal_busy}, 16'h0000);
		st = 8'hEF;
		for (int i = 0; i < 9; i++) begin
			ec[9 + i] = ofs_new[i];
			cmp16(coef[9 + i], ec[9 + i]);
		end
		u_host.sel(1'b1);
		q.push_back(8'hFE);
		u_host.xfer(8'h45, 1'b1);
		for (int p = 0; p < 482; p++) begin
			q.push_back((p < 481) ? exp_b(p) : 8'h00);
			seed = lfsr(seed);
			u_host.xfer((p < 481) ? seed[7:0] : 8'h00, 1'b1);
		end
		u_host.sel(1'b0);
		// Cut dump: the frame end drops the transfer and the answer falls back to idle
		u_host.sel(1'b1);
		q.push_back(8'h00);
		u_host.xfer(8'h45, 1'b1);
		for (int p = 0; p < 2; p++) begin
			q.push_back(exp_b(p));
			u_host.xfer(8'h00, 1'b1);
		end
		u_host.sel(1'b0);
		u_host.sel(1'b1);
		q.push_back(8'h00);
		u_host.xfer(8'h00, 1'b1);
		u_host.sel(1'b0);
		for (int c = 0; c < 4; c++) begin
			@(negedge clk);
			seed = lfsr(seed);
			pulse1_apparent = (c == 1) || ((c == 2) && seed[3]);
			pulse_const = (c == 0) ? 15'h4E20 : (c == 1) ? 15'h0064 :
				(c == 3) ? 15'(32'h000003E8 + seed % 32'h00004A39) : 15'h03E8;
			a0 = n0;
			a1 = n1;
			repeat (10) begin
				@(negedge clk);
				e_act_inc = (c == 0);
				e_app_inc = (c == 1) || (c == 2);
				e_rea_inc = (c == 3);
				@(negedge clk);
				{e_act_inc, e_app_inc, e_rea_inc} = 3'h0;
			end
			repeat (10) @(negedge clk);
			cmp16(16'(n0 - a0), (c == 0) ? 16'h0014 : (c == 1) ? 16'h0001 :
				(c == 2) ? {15'h0000, seed[3]} : 16'h0000);
			// Ten quanta are a thousandth of a kWh: k / 1000 pulses
			cmp16(16'(n1 - a1), (c == 3) ? 16'(pulse_const / 15'h03E8) : 16'h0000);
		end
		final_report();
	end
endmodule

`default_nettype wire
